// file: inc/pw_hdr_pkg.sv
// Purpose: Shared constants for the pseudowire header builder
// Assumes: 32-bit register port, byte offsets, one word per register
// Notes: Encapsulation and field codes are used by the header builder and the bench
package pw_hdr_pkg;
  localparam int REG_AW = 8;
  localparam int ID_W = 20;
  localparam int MAX_WORDS = 4;
  localparam logic [7:0] OFS_CTRL = 8'h00;
  localparam logic [7:0] OFS_LOSS = 8'h04;
  localparam logic [7:0] OFS_TUN0 = 8'h08;
  localparam logic [7:0] OFS_TUN1 = 8'h0C;
  localparam logic [7:0] OFS_COOKIE_HI = 8'h10;
  localparam logic [7:0] OFS_COOKIE_LO = 8'h14;
  localparam logic [7:0] OFS_BSEL = 8'h18;
  localparam logic [7:0] OFS_BCFG = 8'h1C;
  localparam logic [7:0] OFS_STATUS = 8'h20;
  // Control register: TTL and EXP used in every label entry
  localparam int CTRL_TTL_LSB = 0;
  localparam int CTRL_EXP_LSB = 8;
  localparam logic [31:0] CTRL_RST = 32'h0000_00FF;
  // Bundle configuration word
  localparam int BCFG_ID_LSB = 0;
  localparam int BCFG_MODE_LSB = 20;
  localparam int BCFG_TUN_LSB = 22;
  localparam int BCFG_CK_LSB = 24;
  localparam int BCFG_R_BIT = 26;
  localparam int BCFG_PORT_LSB = 27;
  localparam int BCFG_W = 30;
  localparam logic [1:0] ENC_MPLS = 2'h0;
  localparam logic [1:0] ENC_MEF = 2'h1;
  localparam logic [1:0] ENC_L2TP_V4 = 2'h2;
  localparam logic [1:0] ENC_L2TP_V6 = 2'h3;
  localparam logic [1:0] CK_NONE = 2'h0;
  localparam logic [1:0] CK_32 = 2'h1;
  localparam logic [1:0] CK_64 = 2'h2;
  localparam logic [7:0] PROTO_L2TP = 8'h73;
  localparam logic [7:0] PROTO_NONE = 8'h00;
  // Control word layout
  localparam int CW_RES_LSB = 28;
  localparam int CW_L_BIT = 27;
  localparam int CW_R_BIT = 26;
  // Label stack entry layout
  localparam int LBL_LSB = 12;
  localparam int EXP_LSB = 9;
  localparam int BOS_BIT = 8;
  // Status register
  localparam int ST_BUSY_BIT = 0;
  localparam int ST_ERR_BIT = 1;
  localparam int ST_CNT_LSB = 16;
endpackage

// file: rtl/mpls_label_entry.sv
// Purpose: Forms one 32-bit label stack entry
// Assumes: Pure combinational packing
// Notes: Used for both tunnel labels and the bundle label
`timescale 1ns/10ps
`default_nettype none
module mpls_label_entry import pw_hdr_pkg::*; (
  input wire logic [19:0] label_i,
  input wire logic [2:0] exp_i,
  input wire logic bos_i,
  input wire logic [7:0] ttl_i,
  output logic [31:0] word_o
);
  assign word_o = {label_i, exp_i, bos_i, ttl_i};
endmodule
`default_nettype wire

// file: rtl/bundle_cfg_mem.sv
// Purpose: Per-bundle configuration store, one write and two read ports
// Assumes: Read data registered, one cycle after the address
// Notes: Contents are not reset; software loads every bundle in use
`timescale 1ns/10ps
`default_nettype none
module bundle_cfg_mem #(
  parameter int DEPTH = 64,
  parameter int WIDTH = 30,
  parameter int AW = 6
) (
  input wire logic clk_i,
  input wire logic rst_n_i,
  input wire logic we_i,
  input wire logic [AW-1:0] waddr_i,
  input wire logic [WIDTH-1:0] wdata_i,
  input wire logic [AW-1:0] a_addr_i,
  output logic [WIDTH-1:0] a_data_o,
  input wire logic [AW-1:0] b_addr_i,
  output logic [WIDTH-1:0] b_data_o
);
  logic [WIDTH-1:0] mem [DEPTH];

  always_ff @(posedge clk_i) begin
    if (we_i) begin
      mem[waddr_i] <= wdata_i;
    end
  end

  always_ff @(posedge clk_i) begin
    if (!rst_n_i) begin
      a_data_o <= '0;
      b_data_o <= '0;
    end else begin
      a_data_o <= mem[a_addr_i];
      b_data_o <= mem[b_addr_i];
    end
  end
endmodule
`default_nettype wire

// file: rtl/pw_header_control_word_builder.sv
// Purpose: Builds pseudowire encapsulation headers and control word
// Assumes: One packet header at a time; all inputs synchronous to clk_i
// Notes: Words leave on a valid/ready stream, control word last
//
// Added by the designer: the strobed register port and the address map.
`timescale 1ns/10ps
`default_nettype none
// How it works
// - MPLS stack carries zero, one or two tunnels
// - Bottom flag set only on bundle label
// - Innermost label carries the bundle identifier
// - MEF circuit field carries the bundle identifier
// - L2TPv3 over IPv4 uses protocol 0x73
// - L2TPv3 over IPv6 uses next header 0x73
// - Session id is bundle id, zero reserved
// - Optional 32 or 64 bit cookie
// - Control word reserved bits sent as zero
// - L bit copied from port loss setting
// - R bit copied from bundle setting
module pw_header_control_word_builder import pw_hdr_pkg::*; #(
  parameter int NUM_PORTS = 8,
  parameter int NUM_BUNDLES = 64
) (
  input wire logic clk_i,
  input wire logic rst_n_i,
  input wire logic [7:0] reg_addr_i,
  input wire logic [31:0] reg_wdata_i,
  input wire logic reg_we_i,
  input wire logic reg_re_i,
  output logic [31:0] reg_rdata_o,
  input wire logic tx_start_i,
  input wire logic [$clog2(NUM_BUNDLES)-1:0] tx_bundle_i,
  output logic tx_ready_o,
  output logic hdr_valid_o,
  output logic [31:0] hdr_data_o,
  output logic hdr_last_o,
  input wire logic hdr_ready_i,
  output logic [7:0] ip_proto_o,
  output logic hdr_err_o,
  input wire logic rx_valid_i,
  input wire logic [1:0] rx_mode_i,
  input wire logic [31:0] rx_word_i,
  output logic rx_valid_o,
  output logic [19:0] rx_bundle_o,
  output logic rx_drop_o
);
  localparam int BW = $clog2(NUM_BUNDLES);
  localparam int PW = $clog2(NUM_PORTS);
  typedef enum logic [1:0] {ST_IDLE, ST_LOOK, ST_EMIT} tx_state_t;
  tx_state_t state_q;
  logic [31:0] ctrl_q, cookie_hi_q, cookie_lo_q, rdata_q;
  logic [NUM_PORTS-1:0] loss_q;
  logic [19:0] tun0_q, tun1_q;
  logic [BW-1:0] bsel_q;
  logic err_q, rd_cfg_q, cfg_we;
  logic [15:0] pkt_cnt_q;
  logic [BCFG_W-1:0] cfg_a, cfg_b;
  // Transmit capture
  logic [1:0] mode_q;
  logic [19:0] bid_q;
  logic l_snap_q, r_snap_q, first_q, err_pulse_q;
  logic [2:0] left_q;
  logic [31:0] words_q [MAX_WORDS];
  logic [7:0] proto_q;
  // Fields of the looked-up bundle
  logic [19:0] c_id;
  logic [1:0] c_mode, c_tun, c_ck;
  logic c_r, c_l2tp, refuse, hs;
  logic [PW-1:0] c_port;
  logic [31:0] lbl_w [3];
  logic [31:0] cw_w;
  logic [31:0] w_d [MAX_WORDS];
  logic [2:0] n_d;

  assign c_id = cfg_a[BCFG_ID_LSB +: ID_W];
  assign c_mode = cfg_a[BCFG_MODE_LSB +: 2];
  assign c_tun = cfg_a[BCFG_TUN_LSB +: 2];
  assign c_ck = cfg_a[BCFG_CK_LSB +: 2];
  assign c_r = cfg_a[BCFG_R_BIT];
  assign c_port = cfg_a[BCFG_PORT_LSB +: PW];
  assign c_l2tp = (c_mode == ENC_L2TP_V4) || (c_mode == ENC_L2TP_V6);
  // Zero is never a valid session, so such a bundle is refused
  assign refuse = c_l2tp && (c_id == '0);
  assign cfg_we = reg_we_i && (reg_addr_i == OFS_BCFG);
  assign hs = hdr_valid_o && hdr_ready_i;
  bundle_cfg_mem #(
    .DEPTH(NUM_BUNDLES),
    .WIDTH(BCFG_W),
    .AW(BW)
  ) u_cfg (
    .clk_i(clk_i),
    .rst_n_i(rst_n_i),
    .we_i(cfg_we),
    .waddr_i(bsel_q),
    .wdata_i(reg_wdata_i[BCFG_W-1:0]),
    .a_addr_i(tx_bundle_i),
    .a_data_o(cfg_a),
    .b_addr_i(bsel_q),
    .b_data_o(cfg_b)
  );
  // Tunnel labels then bundle label; only the last has the bottom flag
  genvar gi;
  generate
    for (gi = 0; gi < 3; gi++) begin : g_lbl
      mpls_label_entry u_lbl (
        .label_i(gi == 0 ? tun0_q : (gi == 1 ? tun1_q : c_id)),
        .exp_i(ctrl_q[CTRL_EXP_LSB +: 3]),
        .bos_i(gi == 2),
        .ttl_i(ctrl_q[CTRL_TTL_LSB +: 8]),
        .word_o(lbl_w[gi])
      );
    end
  endgenerate
  // Reserved, modifier, fragment, length and sequence left at zero
  always_comb begin
    cw_w = '0;
    cw_w[CW_L_BIT] = loss_q[c_port];
    cw_w[CW_R_BIT] = c_r;
  end
  always_comb begin
    int n;
    n = 0;
    w_d = '{default: '0};
    case (c_mode)
      ENC_MPLS: begin
        if (c_tun != 2'h0) begin
          w_d[n] = lbl_w[0];
          n = n + 1;
        end
        if (c_tun[1]) begin
          w_d[n] = lbl_w[1];
          n = n + 1;
        end
        w_d[n] = lbl_w[2];
        n = n + 1;
      end
      ENC_MEF: begin
        w_d[n] = {c_id, 12'h000};
        n = n + 1;
      end
      default: begin
        w_d[n] = {12'h000, c_id};
        n = n + 1;
        if (c_ck == CK_64) begin
          w_d[n] = cookie_hi_q;
          n = n + 1;
        end
        if (c_ck == CK_64 || c_ck == CK_32) begin
          w_d[n] = cookie_lo_q;
          n = n + 1;
        end
      end
    endcase
    w_d[n] = cw_w;
    n = n + 1;
    n_d = n[2:0];
  end
  // Transmit sequencer
  always_ff @(posedge clk_i) begin
    if (!rst_n_i) begin
      state_q <= ST_IDLE;
      left_q <= 3'h0;
      first_q <= 1'b0;
      err_pulse_q <= 1'b0;
    end else begin
      err_pulse_q <= 1'b0;
      case (state_q)
        ST_IDLE: begin
          if (tx_start_i) begin
            state_q <= ST_LOOK;
          end
        end
        ST_LOOK: begin
          if (refuse) begin
            err_pulse_q <= 1'b1;
            state_q <= ST_IDLE;
          end else begin
            left_q <= n_d;
            first_q <= 1'b1;
            state_q <= ST_EMIT;
          end
        end
        ST_EMIT: begin
          if (hs) begin
            left_q <= left_q - 3'h1;
            first_q <= 1'b0;
            if (left_q == 3'h1) begin
              state_q <= ST_IDLE;
            end
          end
        end
        default: state_q <= ST_IDLE;
      endcase
    end
  end
  // Header words shift out so the data port stays a flop
  always_ff @(posedge clk_i) begin
    if (!rst_n_i) begin
      words_q <= '{default: '0};
      mode_q <= ENC_MPLS;
      bid_q <= '0;
      l_snap_q <= 1'b0;
      r_snap_q <= 1'b0;
      proto_q <= PROTO_NONE;
    end else if (state_q == ST_LOOK && !refuse) begin
      for (int i = 0; i < MAX_WORDS; i++) begin
        words_q[i] <= w_d[i];
      end
      mode_q <= c_mode;
      bid_q <= c_id;
      l_snap_q <= cw_w[CW_L_BIT];
      r_snap_q <= cw_w[CW_R_BIT];
      proto_q <= c_l2tp ? PROTO_L2TP : PROTO_NONE;
    end else if (hs) begin
      for (int i = 0; i < MAX_WORDS - 1; i++) begin
        words_q[i] <= words_q[i+1];
      end
      words_q[MAX_WORDS-1] <= '0;
    end
  end
  assign tx_ready_o = (state_q == ST_IDLE);
  assign hdr_valid_o = (state_q == ST_EMIT);
  assign hdr_data_o = words_q[0];
  assign hdr_last_o = hdr_valid_o && (left_q == 3'h1);
  assign ip_proto_o = proto_q;
  assign hdr_err_o = err_pulse_q;
  // Register writes
  always_ff @(posedge clk_i) begin
    if (!rst_n_i) begin
      ctrl_q <= CTRL_RST;
      loss_q <= '0;
      tun0_q <= '0;
      tun1_q <= '0;
      cookie_hi_q <= '0;
      cookie_lo_q <= '0;
      bsel_q <= '0;
    end else if (reg_we_i) begin
      case (reg_addr_i)
        OFS_CTRL: ctrl_q <= reg_wdata_i;
        OFS_LOSS: loss_q <= reg_wdata_i[NUM_PORTS-1:0];
        OFS_TUN0: tun0_q <= reg_wdata_i[19:0];
        OFS_TUN1: tun1_q <= reg_wdata_i[19:0];
        OFS_COOKIE_HI: cookie_hi_q <= reg_wdata_i;
        OFS_COOKIE_LO: cookie_lo_q <= reg_wdata_i;
        OFS_BSEL: bsel_q <= reg_wdata_i[BW-1:0];
        default: ;
      endcase
    end
  end
  // Error flag: a new refusal wins over a write-one clear
  always_ff @(posedge clk_i) begin
    if (!rst_n_i) begin
      err_q <= 1'b0;
      pkt_cnt_q <= '0;
    end else begin
      if (state_q == ST_LOOK && refuse) begin
        err_q <= 1'b1;
      end else if (reg_we_i && reg_addr_i == OFS_STATUS &&
                   reg_wdata_i[ST_ERR_BIT]) begin
        err_q <= 1'b0;
      end
      if (hdr_last_o && hdr_ready_i) begin
        pkt_cnt_q <= pkt_cnt_q + 16'h0001;
      end
    end
  end
  // Register reads; the bundle word comes straight from the store
  always_ff @(posedge clk_i) begin
    if (!rst_n_i) begin
      rdata_q <= '0;
      rd_cfg_q <= 1'b0;
    end else begin
      rd_cfg_q <= reg_re_i && (reg_addr_i == OFS_BCFG);
      rdata_q <= '0;
      if (reg_re_i) begin
        case (reg_addr_i)
          OFS_CTRL: rdata_q <= ctrl_q;
          OFS_LOSS: rdata_q <= 32'(loss_q);
          OFS_TUN0: rdata_q <= {12'h000, tun0_q};
          OFS_TUN1: rdata_q <= {12'h000, tun1_q};
          OFS_COOKIE_HI: rdata_q <= cookie_hi_q;
          OFS_COOKIE_LO: rdata_q <= cookie_lo_q;
          OFS_BSEL: rdata_q <= 32'(bsel_q);
          OFS_STATUS: rdata_q <= {pkt_cnt_q, 14'h0000, err_q,
                                  state_q != ST_IDLE};
          default: rdata_q <= '0;
        endcase
      end
    end
  end
  assign reg_rdata_o = rd_cfg_q ? 32'(cfg_b) : rdata_q;
  // Receive demultiplexing of the innermost header word
  always_ff @(posedge clk_i) begin
    if (!rst_n_i) begin
      rx_valid_o <= 1'b0;
      rx_bundle_o <= '0;
      rx_drop_o <= 1'b0;
    end else begin
      rx_valid_o <= rx_valid_i;
      rx_drop_o <= 1'b0;
      case (rx_mode_i)
        ENC_MPLS: begin
          rx_bundle_o <= rx_word_i[LBL_LSB +: ID_W];
          rx_drop_o <= rx_valid_i && !rx_word_i[BOS_BIT];
        end
        ENC_MEF: rx_bundle_o <= rx_word_i[LBL_LSB +: ID_W];
        default: begin
          rx_bundle_o <= rx_word_i[ID_W-1:0];
          rx_drop_o <= rx_valid_i && (rx_word_i == '0);
        end
      endcase
    end
  end
  // Checks; lookup fields taken from the build cycle, not the next one
  default clocking cb @(posedge clk_i); endclocking
  default disable iff (!rst_n_i);
  sequence s_build;
    state_q == ST_LOOK && !refuse;
  endsequence
  sequence s_refuse;
    state_q == ST_LOOK && refuse;
  endsequence
  AST_MPLS_DEPTH: assert property (
    s_build and c_mode == ENC_MPLS |=>
      left_q == 3'($past(c_tun[1]) ? 2'h2 : $past(c_tun)) + 3'h2)
    else $error("label stack depth wrong");
  AST_BOS_ONLY_INNER: assert property (
    hdr_valid_o && mode_q == ENC_MPLS |->
      hdr_data_o[BOS_BIT] == (left_q == 3'h2))
    else $error("bottom flag misplaced");
  AST_INNER_ID: assert property (
    hdr_valid_o && mode_q == ENC_MPLS && left_q == 3'h2 |->
      hdr_data_o[LBL_LSB +: ID_W] == bid_q)
    else $error("inner label lacks bundle id");
  AST_MEF_ECID: assert property (
    hdr_valid_o && mode_q == ENC_MEF && first_q |->
      hdr_data_o[LBL_LSB +: ID_W] == bid_q && left_q == 3'h2)
    else $error("circuit field lacks bundle id");
  AST_PROTO_V4: assert property (
    s_build and c_mode == ENC_L2TP_V4 |=> ip_proto_o == PROTO_L2TP)
    else $error("ipv4 protocol not 0x73");
  AST_NEXT_V6: assert property (
    s_build and c_mode == ENC_L2TP_V6 |=>
      (ip_proto_o == PROTO_L2TP) [*2])
    else $error("ipv6 next header not 0x73");
  AST_SESSION: assert property (
    hdr_valid_o && mode_q[1] && first_q |->
      hdr_data_o == {12'h000, bid_q} && hdr_data_o != '0)
    else $error("session id wrong");
  AST_ZERO_REFUSED: assert property (
    s_refuse |=> hdr_err_o && tx_ready_o && !hdr_valid_o)
    else $error("zero session not refused");
  AST_COOKIE_LEN: assert property (
    s_build and c_l2tp |=> left_q == ($past(c_ck) == CK_64 ? 3'h4 :
      ($past(c_ck) == CK_32 ? 3'h3 : 3'h2)))
    else $error("cookie length wrong");
  AST_CW_BITS: assert property (
    hdr_last_o |-> hdr_data_o[31:CW_RES_LSB] == 4'h0 &&
      hdr_data_o[CW_L_BIT] == l_snap_q && hdr_data_o[CW_R_BIT] == r_snap_q)
    else $error("control word flags wrong");
  AST_SAMPLE: assert property (
    s_build |=> l_snap_q == $past(loss_q[c_port]) &&
      r_snap_q == $past(c_r))
    else $error("flags not sampled at build");
endmodule
`default_nettype wire

// file: test/hdr_sink_model.sv
// Purpose: Far-end gateway sink that accepts header words
// Assumes: The far end pushes back only through its ready line
// Notes: Slow mode drops ready every other cycle to stress holding
`timescale 1ns/10ps
`default_nettype none
module hdr_sink_model (
  input wire logic clk_i,
  input wire logic rst_n_i,
  input wire logic slow_i,
  output logic ready_o
);
  logic tog_q;
  always_ff @(posedge clk_i) begin
    if (!rst_n_i) begin
      tog_q <= 1'b0;
    end else begin
      tog_q <= ~tog_q;
    end
  end
  assign ready_o = slow_i ? tog_q : 1'b1;
endmodule
`default_nettype wire

// file: test/tb_top.sv
// Purpose: Self-checking bench for the pseudowire header builder
// Assumes: Globals TTL, EXP, tunnels and cookie set once after reset
// Notes: Header words are collected by a monitor at each handshake
`timescale 1ns/10ps
`default_nettype none
module tb_top import pw_hdr_pkg::*; ;
  logic clk, rst_n, reg_we, reg_re, tx_start, tx_ready, hdr_valid;
  logic hdr_last, hdr_ready, hdr_err, rxv_in, rxv_out, rx_drop, slow;
  logic [7:0] reg_addr, ip_proto, loss_v;
  logic [31:0] reg_wdata, reg_rdata, hdr_data, rx_word, v;
  logic [5:0] tx_bundle;
  logic [1:0] rx_mode;
  logic [19:0] rx_bundle;
  logic [32:0] seen_q[$];
  int failures = 0;
  int cmp_count = 0;
  logic [7:0] ttl = 8'h40;
  logic [2:0] ex = 3'h5;
  logic [19:0] tun0 = 20'hABCDE;
  logic [19:0] tun1 = 20'h12345;
  logic [31:0] ck_hi = 32'hC0FFEE01;
  logic [31:0] ck_lo = 32'h5A5A1234;

  pw_header_control_word_builder pw_header_control_word_builder_inst (
    .clk_i(clk), .rst_n_i(rst_n), .reg_addr_i(reg_addr),
    .reg_wdata_i(reg_wdata), .reg_we_i(reg_we), .reg_re_i(reg_re),
    .reg_rdata_o(reg_rdata), .tx_start_i(tx_start),
    .tx_bundle_i(tx_bundle), .tx_ready_o(tx_ready),
    .hdr_valid_o(hdr_valid), .hdr_data_o(hdr_data),
    .hdr_last_o(hdr_last), .hdr_ready_i(hdr_ready),
    .ip_proto_o(ip_proto), .hdr_err_o(hdr_err), .rx_valid_i(rxv_in),
    .rx_mode_i(rx_mode), .rx_word_i(rx_word), .rx_valid_o(rxv_out),
    .rx_bundle_o(rx_bundle), .rx_drop_o(rx_drop));
  hdr_sink_model hdr_sink_model_inst (.clk_i(clk), .rst_n_i(rst_n),
    .slow_i(slow), .ready_o(hdr_ready));

  always #10 clk = ~clk;
  always @(posedge clk) begin
    if (hdr_valid && hdr_ready) begin
      seen_q.push_back({hdr_last, hdr_data});
    end
  end

  task automatic end_of_test();
    $display("checks %0d failures %0d", cmp_count, failures);
    if (failures == 0 && cmp_count > 0) begin
      $display("DONE - PASS");
    end else begin
      $display("DONE - FAIL");
    end
    $finish;
  endtask

  task automatic check(input string what, input logic [32:0] seen,
                       input logic [32:0] expv);
    cmp_count++;
    if (seen !== expv) begin
      failures++;
      $display("wrong value %s exp %h seen %h", what, expv, seen);
    end
  endtask

  task automatic wr(input logic [7:0] a, input logic [31:0] d);
    @(posedge clk);
    reg_addr <= a;
    reg_wdata <= d;
    reg_we <= 1'b1;
    @(posedge clk);
    reg_we <= 1'b0;
  endtask

  task automatic rd(input logic [7:0] a, output logic [31:0] d);
    @(posedge clk);
    reg_addr <= a;
    reg_re <= 1'b1;
    @(posedge clk);
    reg_re <= 1'b0;
    #1 d = reg_rdata;
  endtask

  task automatic go(input logic [5:0] b);
    seen_q.delete();
    @(posedge clk);
    tx_start <= 1'b1;
    tx_bundle <= b;
    @(posedge clk);
    tx_start <= 1'b0;
  endtask

  function automatic logic [32:0] lbl(input logic [19:0] l, input logic s);
    return {1'b0, l, ex, s, ttl};
  endfunction

  task automatic pkt(input logic [5:0] b, input logic [1:0] mode,
      input logic [1:0] tun, input logic [1:0] ck, input logic [19:0] id,
      input logic r, input logic [2:0] port);
    logic [32:0] expq[$];
    int n;
    wr(OFS_BSEL, {26'h0, b});
    wr(OFS_BCFG, {2'b0, port, r, ck, tun, mode, id});
    if (mode == ENC_MPLS) begin
      if (tun != 2'h0) expq.push_back(lbl(tun0, 1'b0));
      if (tun == 2'h2) expq.push_back(lbl(tun1, 1'b0));
      expq.push_back(lbl(id, 1'b1));
    end else if (mode == ENC_MEF) begin
      expq.push_back({1'b0, id, 12'h0});
    end else begin
      expq.push_back({13'h0, id});
      if (ck == CK_64) expq.push_back({1'b0, ck_hi});
      if (ck != CK_NONE) expq.push_back({1'b0, ck_lo});
    end
    expq.push_back({5'h10, loss_v[port], r, 26'h0});
    go(b);
    n = 0;
    while (!(seen_q.size() > 0 && seen_q[$][32]) && n < 60) begin
      @(posedge clk);
      n++;
    end
    #1;
    check("words", 33'(seen_q.size()), 33'(expq.size()));
    foreach (expq[i]) begin
      if (i < seen_q.size()) begin
        // Tags
        check("word", seen_q[i], expq[i]);
      end
    end
    check("proto", {25'h0, ip_proto},
          {25'h0, mode[1] ? PROTO_L2TP : PROTO_NONE});
  endtask

  task automatic refuse_zero_id();
    wr(OFS_BSEL, 32'h9);
    wr(OFS_BCFG, {2'b0, 3'h1, 1'b0, CK_NONE, 2'h0, ENC_L2TP_V4, 20'h0});
    go(6'h9);
    #1;
    check("busy", {32'h0, tx_ready}, 33'h0);
    @(posedge clk);
    #1;
    check("err", {32'h0, hdr_err}, 33'h1);
    check("ready", {32'h0, tx_ready}, 33'h1);
    repeat (6) @(posedge clk);
    check("none", 33'(seen_q.size()), 33'h0);
    rd(OFS_STATUS, v);
    check("sticky", {32'h0, v[ST_ERR_BIT]}, 33'h1);
    // Eight packets were built before the refused one
    check("count", {17'h0, v[31:16]}, 33'h8);
    rd(OFS_BCFG, v);
    check("bcfg", {1'b0, v},
          {3'h0, 3'h1, 1'b0, CK_NONE, 2'h0, ENC_L2TP_V4, 20'h0});
    wr(OFS_STATUS, 32'h2);
    rd(OFS_STATUS, v);
    check("cleared", {32'h0, v[ST_ERR_BIT]}, 33'h0);
  endtask

  task automatic rx(input logic [1:0] m, input logic [31:0] w,
                    input logic [19:0] b, input logic d);
    @(posedge clk);
    rxv_in <= 1'b1;
    rx_mode <= m;
    rx_word <= w;
    @(posedge clk);
    rxv_in <= 1'b0;
    #1;
    check("rx", {11'h0, rxv_out, rx_bundle, rx_drop}, {11'h0, 1'b1, b, d});
  endtask

  initial begin
    clk = 1'b0;
    rst_n = 1'b0;
    {reg_we, reg_re, tx_start, rxv_in, slow} = 5'h0;
    reg_addr = 8'h00;
    reg_wdata = 32'h0;
    tx_bundle = 6'h0;
    rx_mode = 2'h0;
    rx_word = 32'h0;
    repeat (10) @(posedge clk);
    rst_n <= 1'b1;
    rd(OFS_CTRL, v);
    check("ctrl", {1'b0, v}, {1'b0, CTRL_RST});
    rd(8'h40, v);
    check("unmapped", {1'b0, v}, 33'h0);
    wr(OFS_CTRL, {21'h0, ex, ttl});
    wr(OFS_TUN0, {12'h0, tun0});
    wr(OFS_TUN1, {12'h0, tun1});
    wr(OFS_COOKIE_HI, ck_hi);
    wr(OFS_COOKIE_LO, ck_lo);
    // TDM fault on port 3 reported by software
    loss_v = 8'h08;
    wr(OFS_LOSS, {24'h0, loss_v});
    pkt(6'h1, ENC_MPLS, 2'h0, CK_NONE, 20'h00123, 1'b0, 3'h0);
    pkt(6'h2, ENC_MPLS, 2'h1, CK_NONE, 20'hFEDCB, 1'b1, 3'h3);
    slow = 1'b1;
    pkt(6'h3, ENC_MPLS, 2'h2, CK_NONE, 20'h00ABC, 1'b0, 3'h3);
    slow = 1'b0;
    pkt(6'h4, ENC_MEF, 2'h0, CK_NONE, 20'h5A5A5, 1'b1, 3'h2);
    pkt(6'h5, ENC_L2TP_V4, 2'h0, CK_32, 20'h00777, 1'b1, 3'h7);
    pkt(6'h6, ENC_L2TP_V6, 2'h0, CK_64, 20'hFFFFF, 1'b0, 3'h3);
    pkt(6'h7, ENC_L2TP_V4, 2'h0, CK_NONE, 20'h00001, 1'b0, 3'h1);
    // Fault cleared and packets flowing again: next packet drops L and R
    loss_v = 8'h00;
    wr(OFS_LOSS, {24'h0, loss_v});
    pkt(6'h2, ENC_MPLS, 2'h1, CK_NONE, 20'hFEDCB, 1'b0, 3'h3);
    refuse_zero_id();
    rx(ENC_MPLS, {20'h00ABC, 3'h5, 1'b1, 8'h40}, 20'h00ABC, 1'b0);
    rx(ENC_MPLS, {20'h00ABC, 3'h5, 1'b0, 8'h40}, 20'h00ABC, 1'b1);
    rx(ENC_MEF, {20'h5A5A5, 12'h0}, 20'h5A5A5, 1'b0);
    rx(ENC_L2TP_V6, 32'h0, 20'h0, 1'b1);
    rx(ENC_L2TP_V4, {12'h0, 20'h00777}, 20'h00777, 1'b0);
    end_of_test();
  end

  initial begin
    #200000;
    failures++;
    end_of_test();
  end
endmodule
`default_nettype wire
